/* adcs_params.svh */
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH

`define ADCS_MCLK_NS          50
`define ADCS_CONV60_MS        133
`define ADCS_CONV50_MS        160
`define ADCS_CONVSIM_MS       147
`define ADCS_EXT_CONV_TICKS   20510
`define ADCS_OSC_NS           6500
`define ADCS_OSC_SIM_NS       7150
`define ADCS_EXT_MIN_HZ       2560
`define ADCS_EXT_TMO_PERIODS  2
`define ADCS_SCK_HALF         2'h3
`define ADCS_FRAME_BITS       32
`define ADCS_FRAME_LAST       6'h20
`define ADCS_FRAME_PRELAST    6'h1F
`define ADCS_CNT_W            22
`define ADCS_OSC_W            8
`define ADCS_TMO_W            16
`define ADCS_SYNC_N           4
`define ADCS_SYNC_RST         4'h3
`define ADCS_IX_CS            0
`define ADCS_IX_SCK           1
`define ADCS_IX_NOTCH         2
`define ADCS_IX_SIMV          3
`define ADCS_INIT_CYC         3'h4
`define ADCS_BUF_DEPTH        2
`define ADCS_NS_PER_MS        1000000
`define ADCS_NS_PER_S         1000000000

`endif

/* adcs_pkg.sv */
package adcs_pkg;
	typedef struct packed {
		logic        over;
		logic        under;
		logic        sign;
		logic [23:0] code;
		logic [4:0]  sub;
	} adcs_result_s;

	typedef struct packed {
		logic converting;
		logic ext_clk;
		logic ext_sck;
	} adcs_status_s;

	typedef struct packed {
		logic out;
		logic oe_n;
	} adcs_pin_s;

	typedef logic [31:0] adcs_frame_t;

	typedef enum logic [1:0] {
		ST_CONVERT = 2'h0,
		ST_SLEEP   = 2'h1,
		ST_DOUT    = 2'h3
	} adcs_state_e;
endpackage

/* adcs_seq.sv */
`timescale 1ns/1ns
`include "adcs_params.svh"
// Function
// - internal oscillator: notch pin low picks 60Hz, high picks 50Hz.
// - notch changes outside conversion harmless; inside, only current result may suffer.
// - toggling notch pin detected as external clock, internal oscillator then off.
// - no external clock present: internal oscillator re-enabled automatically.
// - clock source switch harmless in sleep/output; internal serial clock stays valid.
// - internal convert lasts 133ms (60Hz), 160ms (50Hz), 147ms (simultaneous variant).
// - internal serial clock mode drives clock pin, conversion clock divided by 8.
// - data output lasts while select low, at most 32 serial clock cycles.
// - next data bit presented on every falling serial clock edge.
// - clock mode internal at power-up, chosen at each select fall; low means external.
// - select high puts serial data output in high impedance.
// - select low in convert/sleep shows end flag: high converting, low done.
// - after conversion, sleep until rising serial clock with select low.
// - select rising after output began aborts and starts new conversion.
// - select held low converts continuously at maximum configured rate.
// - latest result shifted out most significant bit first.
// - four timing modes: external/internal clock, single cycle or two-wire.
// - frame is flag, zero bit, sign, 24-bit result, five sub bits.
// - 32nd falling edge (external clock) or 32nd rising edge (internal clock) drives data high and starts new conversion.
// - overrange sets sign and msb, underrange clears both; result clamped.
module adcs_seq #(
	parameter int unsigned CONV60_CYC  = (`ADCS_CONV60_MS * `ADCS_NS_PER_MS) / `ADCS_MCLK_NS,
	parameter int unsigned CONV50_CYC  = (`ADCS_CONV50_MS * `ADCS_NS_PER_MS) / `ADCS_MCLK_NS,
	parameter int unsigned CONVSIM_CYC = (`ADCS_CONVSIM_MS * `ADCS_NS_PER_MS) / `ADCS_MCLK_NS,
	parameter int unsigned EXT_TMO_CYC = `ADCS_EXT_TMO_PERIODS
		* ((`ADCS_NS_PER_S + `ADCS_EXT_MIN_HZ * `ADCS_MCLK_NS - 1) / (`ADCS_EXT_MIN_HZ * `ADCS_MCLK_NS))
) (
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	input  wire logic                  cs_n,
	input  wire logic                  sck_in,
	input  wire logic                  notch_select_pin,
	input  wire logic                  sim_variant,
	input  wire adcs_pkg::adcs_result_s res_in,
	input  wire logic                  res_valid,
	output logic                       res_ready,
	output adcs_pkg::adcs_pin_s         sck_pin,
	output adcs_pkg::adcs_pin_s         sdo_pin,
	output logic                       conv_start,
	output adcs_pkg::adcs_status_s      status
);
	import adcs_pkg::*;

	localparam int unsigned OSC_CYC     = `ADCS_OSC_NS / `ADCS_MCLK_NS;
	localparam int unsigned OSC_SIM_CYC = `ADCS_OSC_SIM_NS / `ADCS_MCLK_NS;
	localparam logic [`ADCS_SYNC_N-1:0] SYNC_RST = `ADCS_SYNC_RST;

	logic [`ADCS_SYNC_N-1:0] s1_ff;
	logic [`ADCS_SYNC_N-1:0] s2_ff;
	logic [`ADCS_SYNC_N-1:0] s3_ff;
	logic [`ADCS_SYNC_N-1:0] filt_ff;
	logic [`ADCS_SYNC_N-1:0] prev_ff;
	adcs_state_e             state_ff;
	adcs_state_e             nxt_state;
	logic [`ADCS_CNT_W-1:0]  conv_cnt_ff;
	logic [`ADCS_CNT_W-1:0]  conv_target;
	logic [`ADCS_OSC_W-1:0]  osc_cnt_ff;
	logic [`ADCS_OSC_W-1:0]  osc_last;
	logic [`ADCS_TMO_W-1:0]  tmo_cnt_ff;
	logic [1:0]              edge_cnt_ff;
	logic                    ext_clk_ff;
	logic                    ext_sck_ff;
	logic [2:0]              init_cnt_ff;
	logic                    sck_int_ff;
	logic [1:0]              div_cnt_ff;
	logic [5:0]              rise_cnt_ff;
	adcs_frame_t             frame_ff;
	adcs_result_s            last_res_ff;
	adcs_result_s            buf_ff [`ADCS_BUF_DEPTH];
	logic                    wr_ptr_ff;
	logic                    rd_ptr_ff;
	logic [1:0]              fill_ff;
	logic                    conv_start_ff;

	logic cs_q;
	logic sck_q;
	logic notch_q;
	logic simv_q;
	logic cs_fall;
	logic cs_rise;
	logic notch_rise;
	logic tmo_hit;
	logic conv_tick;
	logic conv_done;
	logic run_int;
	logic int_toggle;
	logic sck_rise;
	logic sck_fall;
	logic end_xfer;
	logic abort_xfer;
	logic push;
	logic pop;
	adcs_result_s load_res;

	// frame layout: flag, zero, sign, result, sub bits; out of range forces a clamped code
	function automatic adcs_frame_t build_frame(input adcs_result_s r);
		adcs_frame_t f;
		f = {1'b0, 1'b0, r.sign, r.code, r.sub};
		if (r.over) begin
			f = {3'h1, 1'b1, 23'h000000, 5'h00};
		end else if (r.under) begin
			f = {3'h0, 1'b0, 23'h7FFFFF, 5'h1F};
		end
		return f;
	endfunction

	// three stages, the change is taken once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < `ADCS_SYNC_N; gi++) begin : g_sync
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					s1_ff[gi]   <= SYNC_RST[gi];
					s2_ff[gi]   <= SYNC_RST[gi];
					s3_ff[gi]   <= SYNC_RST[gi];
					filt_ff[gi] <= SYNC_RST[gi];
					prev_ff[gi] <= SYNC_RST[gi];
				end else begin
					s1_ff[gi] <= (gi == `ADCS_IX_CS) ? cs_n : (gi == `ADCS_IX_SCK) ? sck_in :
						(gi == `ADCS_IX_NOTCH) ? notch_select_pin : sim_variant;
					s2_ff[gi] <= s1_ff[gi];
					s3_ff[gi] <= s2_ff[gi];
					if (s2_ff[gi] == s3_ff[gi]) begin
						filt_ff[gi] <= s3_ff[gi];
					end
					prev_ff[gi] <= filt_ff[gi];
				end
			end
		end
	endgenerate

	assign cs_q       = filt_ff[`ADCS_IX_CS];
	assign sck_q      = filt_ff[`ADCS_IX_SCK];
	assign notch_q    = filt_ff[`ADCS_IX_NOTCH];
	assign simv_q     = filt_ff[`ADCS_IX_SIMV];
	assign cs_fall    = prev_ff[`ADCS_IX_CS] & ~cs_q;
	assign cs_rise    = ~prev_ff[`ADCS_IX_CS] & cs_q;
	assign notch_rise = ~prev_ff[`ADCS_IX_NOTCH] & notch_q;
	assign tmo_hit    = (tmo_cnt_ff == `ADCS_TMO_W'(EXT_TMO_CYC));

	// two edges inside the timeout are needed, so a static level change is not taken as a clock
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tmo_cnt_ff  <= '0;
			edge_cnt_ff <= 2'h0;
			ext_clk_ff  <= 1'b0;
		end else if (notch_rise) begin
			tmo_cnt_ff <= '0;
			if (edge_cnt_ff != 2'h2) begin
				edge_cnt_ff <= edge_cnt_ff + 2'h1;
			end
			if (edge_cnt_ff != 2'h0) begin
				ext_clk_ff <= 1'b1;
			end
		end else if (tmo_hit) begin
			edge_cnt_ff <= 2'h0;
			ext_clk_ff  <= 1'b0;
		end else begin
			tmo_cnt_ff <= tmo_cnt_ff + `ADCS_TMO_W'(1);
		end
	end

	// internal oscillator runs only while no external clock is present
	assign osc_last = simv_q ? `ADCS_OSC_W'(OSC_SIM_CYC - 1) : `ADCS_OSC_W'(OSC_CYC - 1);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			osc_cnt_ff <= '0;
		end else if (ext_clk_ff || osc_cnt_ff >= osc_last) begin
			osc_cnt_ff <= '0;
		end else begin
			osc_cnt_ff <= osc_cnt_ff + `ADCS_OSC_W'(1);
		end
	end

	assign conv_tick = ext_clk_ff ? notch_rise : (osc_cnt_ff == osc_last);

	// target follows the pins live, so a change mid-conversion only bends the current one
	always_comb begin
		if (ext_clk_ff) begin
			conv_target = `ADCS_CNT_W'(`ADCS_EXT_CONV_TICKS);
		end else if (simv_q) begin
			conv_target = `ADCS_CNT_W'(CONVSIM_CYC);
		end else if (notch_q) begin
			conv_target = `ADCS_CNT_W'(CONV50_CYC);
		end else begin
			conv_target = `ADCS_CNT_W'(CONV60_CYC);
		end
	end

	assign conv_done = (state_ff == ST_CONVERT) && (conv_cnt_ff >= conv_target - `ADCS_CNT_W'(1)) &&
		(!ext_clk_ff || notch_rise);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			conv_cnt_ff <= '0;
		end else if (state_ff != ST_CONVERT || conv_done) begin
			conv_cnt_ff <= '0;
		end else if (!ext_clk_ff || notch_rise) begin
			conv_cnt_ff <= conv_cnt_ff + `ADCS_CNT_W'(1);
		end
	end

	// mode capture ends the cycle before the pin reaches the filter, so after reset it always takes the high reset level
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			init_cnt_ff <= 3'h0;
			ext_sck_ff  <= 1'b0;
		end else if (init_cnt_ff != `ADCS_INIT_CYC) begin
			init_cnt_ff <= init_cnt_ff + 3'h1;
			ext_sck_ff  <= ~sck_q;
		end else if (cs_fall) begin
			ext_sck_ff <= ~sck_q;
		end
	end

	assign run_int    = ~ext_sck_ff & ~cs_q & (state_ff == ST_SLEEP || state_ff == ST_DOUT);
	assign int_toggle = run_int & conv_tick & (div_cnt_ff == `ADCS_SCK_HALF);

	// four conversion ticks per half period; a source switch only stretches one half
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			div_cnt_ff <= 2'h0;
			sck_int_ff <= 1'b1;
		end else begin
			if (!run_int) begin
				div_cnt_ff <= 2'h0;
			end else if (conv_tick) begin
				div_cnt_ff <= div_cnt_ff + 2'h1;
			end
			if (cs_fall) begin
				sck_int_ff <= 1'b0;
			end else if (end_xfer || abort_xfer) begin
				sck_int_ff <= 1'b1;
			end else if (int_toggle) begin
				sck_int_ff <= ~sck_int_ff;
			end
		end
	end

	always_comb begin
		if (ext_sck_ff) begin
			sck_rise = ~prev_ff[`ADCS_IX_SCK] & sck_q & ~cs_q;
			sck_fall = prev_ff[`ADCS_IX_SCK] & ~sck_q & ~cs_q;
		end else begin
			sck_rise = int_toggle & ~sck_int_ff;
			sck_fall = int_toggle & sck_int_ff;
		end
	end

	assign abort_xfer = (state_ff == ST_DOUT) && cs_rise;
	assign end_xfer   = (state_ff == ST_DOUT) && !cs_rise &&
		(ext_sck_ff ? (sck_fall && rise_cnt_ff == `ADCS_FRAME_LAST)
		            : (sck_rise && rise_cnt_ff == `ADCS_FRAME_PRELAST));

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_CONVERT: begin
				if (conv_done) begin
					nxt_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (sck_rise && !cs_q) begin
					nxt_state = ST_DOUT;
				end
			end
			ST_DOUT: begin
				if (abort_xfer || end_xfer) begin
					nxt_state = ST_CONVERT;
				end
			end
			default: begin
				nxt_state = ST_CONVERT;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_ff      <= ST_CONVERT;
			conv_start_ff <= 1'b0;
		end else begin
			state_ff      <= nxt_state;
			conv_start_ff <= (state_ff != ST_CONVERT) && (nxt_state == ST_CONVERT);
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rise_cnt_ff <= 6'h00;
		end else if (state_ff == ST_SLEEP && nxt_state == ST_DOUT) begin
			rise_cnt_ff <= 6'h01;
		end else if (state_ff == ST_DOUT && sck_rise) begin
			rise_cnt_ff <= rise_cnt_ff + 6'h01;
		end
	end

	// two-entry buffer: the filter may finish a word while the previous one still waits
	assign res_ready = (fill_ff != 2'h2);
	assign push      = res_valid & res_ready;
	assign pop       = conv_done & (fill_ff != 2'h0);
	assign load_res  = pop ? buf_ff[rd_ptr_ff] : last_res_ff;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			fill_ff   <= 2'h0;
			buf_ff[0] <= '0;
			buf_ff[1] <= '0;
		end else begin
			if (push) begin
				buf_ff[wr_ptr_ff] <= res_in;
				wr_ptr_ff         <= ~wr_ptr_ff;
			end
			if (pop) begin
				rd_ptr_ff <= ~rd_ptr_ff;
			end
			fill_ff <= fill_ff + {1'b0, push} - {1'b0, pop};
		end
	end

	// a missing word repeats the previous result rather than stalling the cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			last_res_ff <= '0;
			frame_ff    <= '0;
		end else if (conv_done) begin
			last_res_ff <= load_res;
			frame_ff    <= build_frame(load_res);
		end else if (state_ff == ST_DOUT && sck_fall && !end_xfer) begin
			frame_ff <= {frame_ff[`ADCS_FRAME_BITS-2:0], 1'b1};
		end
	end

	assign sdo_pin.out  = (state_ff == ST_CONVERT) ? 1'b1 : frame_ff[`ADCS_FRAME_BITS-1];
	assign sdo_pin.oe_n = cs_q;
	assign sck_pin.out  = sck_int_ff;
	// mode is still being taken at the select fall, so the pin stays released for that cycle
	assign sck_pin.oe_n = ext_sck_ff | cs_q | cs_fall;
	assign conv_start   = conv_start_ff;
	assign status       = '{converting: (state_ff == ST_CONVERT), ext_clk: ext_clk_ff, ext_sck: ext_sck_ff};

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_dout_entry;
		state_ff == ST_SLEEP && sck_rise && !cs_q;
	endsequence

	sequence s_dout_held;
		state_ff == ST_DOUT && rise_cnt_ff == 6'h01;
	endsequence

	a_sdo_hiz_cs: assert property (cs_q |-> sdo_pin.oe_n)
		else $error("data pin driven while select high");
	a_eoc_busy: assert property (state_ff == ST_CONVERT && !cs_q |-> sdo_pin.out && !sdo_pin.oe_n)
		else $error("end flag not high during conversion");
	a_sleep_flag: assert property (conv_done |=> state_ff == ST_SLEEP && !sdo_pin.out)
		else $error("end flag not low after conversion");
	a_sleep_exit: assert property (s_dout_entry |=> s_dout_held)
		else $error("rising clock in sleep did not start output");
	a_abort_cs: assert property (abort_xfer |=> state_ff == ST_CONVERT && conv_start)
		else $error("select rise did not abort");
	a_frame_len: assert property (state_ff == ST_DOUT |-> rise_cnt_ff <= `ADCS_FRAME_LAST)
		else $error("output longer than 32 clocks");
	a_end_high: assert property (end_xfer |=> state_ff == ST_CONVERT && sdo_pin.out)
		else $error("frame end did not restart conversion");
	a_shift_fall: assert property (state_ff == ST_DOUT && sck_fall && !end_xfer && !cs_rise
		|=> frame_ff == {$past(frame_ff[30:0]), 1'b1})
		else $error("bit not advanced on falling clock");
	a_mode_sel: assert property (init_cnt_ff == `ADCS_INIT_CYC && cs_fall |=> ext_sck_ff == !$past(sck_q))
		else $error("clock mode not taken at select fall");
	a_sck_drive: assert property (!ext_sck_ff && !cs_q && !cs_fall |-> !sck_pin.oe_n)
		else $error("internal clock not driven");
	a_ext_drop: assert property (tmo_hit && !notch_rise |=> !ext_clk_ff)
		else $error("external clock kept after timeout");
	a_clamp_over: assert property (conv_done && load_res.over |=> frame_ff[29:28] == 2'h3)
		else $error("overrange not flagged");
	a_conv_restart: assert property ($rose(state_ff == ST_CONVERT) |-> conv_cnt_ff == '0)
		else $error("conversion timer not cleared at start");
endmodule

/* adcs_host.sv */
`timescale 1ns/1ns
module adcs_host (
	input  wire logic                mclk,
	input  wire adcs_pkg::adcs_pin_s sdo_pin,
	input  wire adcs_pkg::adcs_pin_s sck_pin,
	output logic                     cs_n,
	output logic                     sck_in,
	output logic                     sdo_line,
	output adcs_pkg::adcs_frame_t    frame_got,
	output logic                     frame_done
);
	import adcs_pkg::*;
	logic sck_drv;
	logic sck_en;
	logic sdo_last;
	// weak pull-up when neither side drives the clock line
	assign sck_in = !sck_pin.oe_n ? sck_pin.out : (sck_en ? sck_drv : 1'b1);
	// released data line shows the inverse of its last level, not a stale copy
	assign sdo_line = sdo_pin.oe_n ? ~sdo_last : sdo_pin.out;
	always @(posedge mclk) begin
		if (!sdo_pin.oe_n)
			sdo_last <= sdo_pin.out;
	end
	initial begin
		cs_n = 1'b1;
		sck_en = 1'b0;
		sck_drv = 1'b0;
		sdo_last = 1'b0;
		frame_got = '0;
		frame_done = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task automatic read(input bit intl, input int nbits, output int wait_cyc, output int per);
		adcs_frame_t f;
		int          i;
		int          t;
		int          t1;
		logic        prev;
		logic        sp;
		per = 0;
		f = '0;
		i = 0;
		t = 0;
		t1 = 0;
		if (cs_n || sck_en == intl) begin
			cs_n = 1'b1;
			tick(8);
			sck_en = !intl;
			sck_drv = 1'b0;
			tick(8);
			cs_n = 1'b0;
			tick(8);
		end
		wait_cyc = 0;
		while (sdo_line !== 1'b0 && wait_cyc < 8000) begin
			tick(1);
			wait_cyc++;
		end
		if (!intl) begin
			// bit taken late in the high phase, once the synchronised shift has landed
			for (i = 0; i < nbits; i++) begin
				sck_drv = 1'b1;
				tick(4);
				f = {f[30:0], sdo_line};
				sck_drv = 1'b0;
				tick(4);
			end
		end else begin
			prev = sck_in;
			sp = sdo_line;
			// data taken from the cycle before the rise, as a real latch would
			while (i < nbits && t < 60000) begin
				tick(1);
				t++;
				if (sck_in && !prev) begin
					f = {f[30:0], sp};
					i++;
					if (i == 1)
						t1 = t;
					if (i == 2)
						per = t - t1;
				end
				prev = sck_in;
				sp = sdo_line;
			end
		end
		if (nbits < 32) begin
			cs_n = 1'b1;
		end else begin
			frame_got = f;
			frame_done = 1'b1;
			tick(1);
			frame_done = 1'b0;
		end
	endtask
endmodule

/* adcs_conversion_sequencer_serial_port_test.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
	$display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module adcs_conversion_sequencer_serial_port_test;
	import adcs_pkg::*;
	localparam int C60 = 2000;
	localparam int C50 = 2600;
	localparam int TMO = 200;
	localparam int CSIM = 2300;
	logic         mclk, resetn, cs_n, sck_in, notch, res_valid, res_ready, conv_start, sdo_line, frame_done;
	adcs_result_s res_in;
	adcs_pin_s    sck_pin, sdo_pin;
	adcs_status_s status;
	logic         simv;
	adcs_frame_t  frame_got, fexp;
	adcs_frame_t  exp_q[$];
	adcs_result_s w[6];
	logic [31:0]  r;
	int           num_errors, total_checks, cycles, wc, per, n, k;
	always #25 mclk = ~mclk;
	adcs_seq #(.CONV60_CYC(C60), .CONV50_CYC(C50), .CONVSIM_CYC(CSIM), .EXT_TMO_CYC(TMO)) adcs_seq_inst (
		.mclk(mclk), .resetn(resetn), .cs_n(cs_n), .sck_in(sck_in), .notch_select_pin(notch),
		.sim_variant(simv), .res_in(res_in), .res_valid(res_valid), .res_ready(res_ready),
		.sck_pin(sck_pin), .sdo_pin(sdo_pin), .conv_start(conv_start), .status(status));
	adcs_host adcs_host_inst (.mclk(mclk), .sdo_pin(sdo_pin), .sck_pin(sck_pin), .cs_n(cs_n),
		.sck_in(sck_in), .sdo_line(sdo_line), .frame_got(frame_got), .frame_done(frame_done));
	function automatic adcs_frame_t frm(input adcs_result_s v);
		if (v.over)
			return 32'h30000000;
		if (v.under)
			return 32'h0FFFFFFF;
		return {2'b00, v.sign, v.code, v.sub};
	endfunction
	task automatic tick(input int c);
		repeat (c) @(posedge mclk);
		#2;
	endtask
	// every conversion end pops one word while the buffer holds one, aborted reads included
	task automatic rd(input bit intl, input int nbits);
		if (nbits == 32)
			exp_q.push_back(frm(w[k]));
		k++;
		adcs_host_inst.read(intl, nbits, wc, per);
		`CHK(wc < 8000, 1'b1)
	endtask
	task summarize;
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			summarize();
		end
	end
	always @(posedge mclk) begin
		if (frame_done === 1'b1) begin
			fexp = exp_q.pop_front();
			`CHK(frame_got, fexp)
		end
	end
	initial begin
		mclk = 1'b0;
		resetn = 1'b0;
		notch = 1'b0;
		simv = 1'b0;
		res_valid = 1'b0;
		res_in = '0;
		{cycles, num_errors, total_checks, k} = '0;
		void'($urandom(95559));
		for (int i = 0; i < 6; i++) begin
			r = $urandom;
			w[i] = {2'b00, r[0], ~r[0], r[23:1], r[28:24]};
		end
		w[2].over = 1'b1;
		w[3].under = 1'b1;
		repeat (3) @(posedge mclk);
		`CHK(sdo_pin.oe_n, 1'b1)
		`CHK(sck_pin.oe_n, 1'b1)
		`CHK(conv_start, 1'b0)
		#2;
		resetn = 1'b1;
		fork
			begin
				for (int j = 0; j < 6; j++) begin
					res_in = w[j];
					res_valid = 1'b1;
					while (res_ready !== 1'b1) tick(1);
					tick(1);
				end
				res_valid = 1'b0;
			end
		join_none
		tick(8);
		`CHK(res_ready, 1'b0)
		rd(0, 32);
		`CHK(status.ext_sck, 1'b1)
		rd(0, 32);
		`CHK(wc >= C60 - 8 && wc <= C60 + 8, 1'b1)
		tick(3);
		`CHK(sdo_line, 1'b1)
		`CHK(sck_pin.oe_n, 1'b1)
		// mid-conversion notch change may spoil only the conversion in progress
		notch = 1'b1;
		rd(0, 32);
		rd(0, 32);
		`CHK(wc >= C50 - 8 && wc <= C50 + 8, 1'b1)
		rd(0, 5);
		n = 0;
		while (conv_start !== 1'b1 && n < 12) begin
			tick(1);
			n++;
		end
		`CHK(n < 12, 1'b1)
		tick(8);
		`CHK(sdo_pin.oe_n, 1'b1)
		notch = 1'b0;
		rd(1, 32);
		`CHK(wc >= C60 - 60 && wc <= C60, 1'b1)
		`CHK(per, 1040)
		`CHK(sck_pin.oe_n, 1'b0)
		`CHK(status.ext_sck, 1'b0)
		tick(4);
		`CHK(sdo_line, 1'b1)
		// simultaneous variant: longer conversion and slower internal clock, read cut after two bits
		simv = 1'b1;
		rd(1, 2);
		`CHK(wc >= CSIM - 8 && wc <= CSIM, 1'b1)
		`CHK(per, 1144)
		simv = 1'b0;
		for (int j = 0; j < 30; j++) begin
			notch = 1'b1;
			tick(10);
			notch = 1'b0;
			tick(10);
		end
		`CHK(status.ext_clk, 1'b1)
		tick(TMO + 20);
		`CHK(status.ext_clk, 1'b0)
		summarize();
	end
endmodule
